// ===== hw/pdpoc_top.sv
// APB-reached direction and pin option configuration for up to four 8-bit ports
//
// Summary of operation
// - One to four ports, each two registers
// - Reset makes all pins inputs to MCU
// - Eight direction bits, bit n is pin n
// - Direction zero drives output, one is input
// - Option register holds pin options apart
// - Each option write configures at most one pin
// - Setup write records pin and option kind
// - Option read returns mode in bits 7:5
// - Bits 2:0 pin, 3 setup, 4 kind
// - Setup saves selection; otherwise mode is updated, except illegal output codes
// - Output modes 000 normal, 011 high drive
// - Input modes: plain, pull-down, pull-up, off
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module pdpoc_top #(
  parameter int NUM_PORTS = pdpoc_pkg::PDPOC_MAX_PORTS,
  parameter int ADDR_W = pdpoc_pkg::PDPOC_ADDR_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NUM_PORTS*8-1:0] PIN_IN,
  input wire logic [NUM_PORTS*8-1:0] PORT_OUT_DATA,
  output logic [NUM_PORTS*8-1:0] PORT_IN_DATA,
  output logic [NUM_PORTS*8-1:0] PIN_OUT,
  output logic [NUM_PORTS*8-1:0] PIN_OE,
  output logic [NUM_PORTS*8-1:0] PIN_HIGH_DRIVE,
  output logic [NUM_PORTS*8-1:0] PIN_IN_EN,
  output logic [NUM_PORTS*8-1:0] PIN_PULL_UP,
  output logic [NUM_PORTS*8-1:0] PIN_PULL_DOWN
);

  localparam int NPINS = NUM_PORTS * pdpoc_pkg::PDPOC_PINS;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (NUM_PORTS < 1 || NUM_PORTS > pdpoc_pkg::PDPOC_MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end
  if (ADDR_W < pdpoc_pkg::PDPOC_IDX_W + 2 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must hold a register index times four");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // One-hot hit over the implemented ports for either register table
  function automatic logic [pdpoc_pkg::PDPOC_MAX_PORTS-1:0] hit_vec(
    input logic [ADDR_W-1:0] addr,
    input logic is_opt
  );
    logic [pdpoc_pkg::PDPOC_MAX_PORTS-1:0] h;
    logic [pdpoc_pkg::PDPOC_IDX_W+1:0] byte_addr;
    h = '0;
    byte_addr = '0;
    for (int p = 0; p < pdpoc_pkg::PDPOC_MAX_PORTS; p++) begin
      byte_addr = is_opt ? {pdpoc_pkg::PDPOC_OPT_IDX[p], 2'b00} : {pdpoc_pkg::PDPOC_DIR_IDX[p], 2'b00};
      h[p] = (p < NUM_PORTS) && (addr == ADDR_W'(byte_addr));
    end
    return h;
  endfunction

  logic [pdpoc_pkg::PDPOC_MAX_PORTS-1:0] dir_hit;
  logic [pdpoc_pkg::PDPOC_MAX_PORTS-1:0] opt_hit;
  logic any_hit;

  assign dir_hit = hit_vec(PADDR, 1'b0);
  assign opt_hit = hit_vec(PADDR, 1'b1);
  assign any_hit = |{dir_hit, opt_hit};

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: read data and error are captured in the setup cycle,
  // so the access phase always completes with no wait state

  pdpoc_pkg::pdpoc_apb_t apb_state;
  pdpoc_pkg::pdpoc_apb_t next_apb_state;
  logic setup_cycle;
  logic wr_fire;
  logic slverr;
  logic [31:0] next_prdata;

  assign setup_cycle = PSEL && !PENABLE;

  always_comb begin
    next_apb_state = apb_state;
    unique case (apb_state)
      pdpoc_pkg::PDPOC_APB_IDLE: begin
        if (setup_cycle) begin
          next_apb_state = pdpoc_pkg::PDPOC_APB_ACCESS;
        end
      end
      pdpoc_pkg::PDPOC_APB_ACCESS: begin
        if (!(PSEL && PENABLE)) begin
          next_apb_state = setup_cycle ? pdpoc_pkg::PDPOC_APB_ACCESS : pdpoc_pkg::PDPOC_APB_IDLE;
        end else begin
          next_apb_state = pdpoc_pkg::PDPOC_APB_IDLE;
        end
      end
      default: begin
        next_apb_state = pdpoc_pkg::PDPOC_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      apb_state <= pdpoc_pkg::PDPOC_APB_IDLE;
    end else begin
      apb_state <= next_apb_state;
    end
  end

  assign PREADY = (apb_state == pdpoc_pkg::PDPOC_APB_ACCESS) && PSEL && PENABLE;
  assign PSLVERR = PREADY && slverr;
  assign wr_fire = PREADY && PWRITE && any_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port registers

  logic [NPINS-1:0] dir_all;
  logic [NPINS-1:0][2:0] out_mode_all;
  logic [NPINS-1:0][1:0] in_mode_all;
  logic [NUM_PORTS-1:0][2:0] rd_mode_all;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pdpoc_dir_reg u_dir (
      .clk(CLK),
      .reset(RESET),
      .wr_en(wr_fire && dir_hit[p]),
      .wdata(PWDATA[7:0]),
      .dir(dir_all[p*8 +: 8])
    );

    // Option writes are indirect; only the addressed pin moves
    pdpoc_option_port u_opt (
      .clk(CLK),
      .reset(RESET),
      .wr_en(wr_fire && opt_hit[p]),
      .wdata(PWDATA[7:0]),
      .out_mode(out_mode_all[p*8 +: 8]),
      .in_mode(in_mode_all[p*8 +: 8]),
      .rd_mode(rd_mode_all[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    next_prdata = pdpoc_pkg::PDPOC_RDATA_ZERO;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (dir_hit[p]) begin
        next_prdata[7:0] = dir_all[p*8 +: 8];
      end
      if (opt_hit[p]) begin
        // Only the mode field reads back; the write-only fields read zero
        next_prdata[pdpoc_pkg::PDPOC_MODE_LSB +: pdpoc_pkg::PDPOC_MODE_W] = rd_mode_all[p];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= pdpoc_pkg::PDPOC_RDATA_ZERO;
    end else if (setup_cycle && !PWRITE) begin
      PRDATA <= next_prdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      slverr <= 1'b0;
    end else if (setup_cycle) begin
      slverr <= !any_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin control, registered so the pad side sees clean levels

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIN_OE <= '0;
      PIN_IN_EN <= '1;
      PIN_OUT <= '0;
      PIN_HIGH_DRIVE <= '0;
      PIN_PULL_UP <= '0;
      PIN_PULL_DOWN <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        PIN_OE[i] <= !dir_all[i];
        PIN_OUT[i] <= PORT_OUT_DATA[i];
        PIN_HIGH_DRIVE[i] <= out_mode_all[i] == pdpoc_pkg::PDPOC_OUT_HIGH;
        PIN_IN_EN[i] <= in_mode_all[i] != pdpoc_pkg::PDPOC_IN_OFF;
        PIN_PULL_UP[i] <= in_mode_all[i] == pdpoc_pkg::PDPOC_IN_PULLUP;
        PIN_PULL_DOWN[i] <= in_mode_all[i] == pdpoc_pkg::PDPOC_IN_PULLDOWN;
      end
    end
  end

  // A disabled input buffer reads zero rather than a floating pad
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PORT_IN_DATA <= '0;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        PORT_IN_DATA[i] <= PIN_IN[i] && (in_mode_all[i] != pdpoc_pkg::PDPOC_IN_OFF);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [7:0] wbyte;
  int unsigned changed_pins;
  logic [NPINS-1:0][2:0] last_out_mode;
  logic [NPINS-1:0][1:0] last_in_mode;

  assign wbyte = PWDATA[7:0];

  // Copy of last cycle's modes, so the per-write pin count needs no sampled-value call
  always_ff @(posedge CLK) begin
    last_out_mode <= out_mode_all;
    last_in_mode <= in_mode_all;
  end

  always_comb begin
    changed_pins = 0;
    for (int i = 0; i < NPINS; i++) begin
      if (out_mode_all[i] != last_out_mode[i] || in_mode_all[i] != last_in_mode[i]) begin
        changed_pins++;
      end
    end
  end

  property p_reset_inputs;
    @(posedge CLK) $fell(RESET) |-> (dir_all == '1) && (PIN_OE == '0) && (PIN_IN_EN == '1);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");

  property p_oe_from_dir;
    @(posedge CLK) disable iff (RESET)
    !$past(RESET) |-> PIN_OE == ~$past(dir_all);
  endproperty
  a_oe_from_dir: assert property (p_oe_from_dir) else $error("output enable does not follow direction");

  property p_dir_write;
    @(posedge CLK) disable iff (RESET)
    (wr_fire && dir_hit[0]) |=> dir_all[7:0] == $past(wbyte);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not stored");

  property p_one_pin_per_write;
    @(posedge CLK) disable iff (RESET)
    !$past(RESET) |-> changed_pins <= 1;
  endproperty
  a_one_pin_per_write: assert property (p_one_pin_per_write) else $error("option write changed several pins");

  property p_setup_keeps_modes;
    @(posedge CLK) disable iff (RESET)
    (wr_fire && (|opt_hit) && wbyte[pdpoc_pkg::PDPOC_RDSET_BIT]) |=>
      $stable(out_mode_all) && $stable(in_mode_all);
  endproperty
  a_setup_keeps_modes: assert property (p_setup_keeps_modes) else $error("setup write altered a mode");

  property p_out_update;
    @(posedge CLK) disable iff (RESET)
    (wr_fire && opt_hit[0] && !wbyte[pdpoc_pkg::PDPOC_RDSET_BIT] &&
     wbyte[pdpoc_pkg::PDPOC_KIND_BIT] == pdpoc_pkg::PDPOC_KIND_OUT &&
     wbyte[7:5] == pdpoc_pkg::PDPOC_OUT_HIGH) |=> out_mode_all[$past(wbyte[2:0])] == pdpoc_pkg::PDPOC_OUT_HIGH;
  endproperty
  a_out_update: assert property (p_out_update) else $error("output mode not updated");

  property p_in_update;
    @(posedge CLK) disable iff (RESET)
    (wr_fire && opt_hit[1] && !wbyte[pdpoc_pkg::PDPOC_RDSET_BIT] &&
     wbyte[pdpoc_pkg::PDPOC_KIND_BIT] == pdpoc_pkg::PDPOC_KIND_IN) |=>
      in_mode_all[{1'b1, $past(wbyte[2:0])}] == $past(wbyte[6:5]);
  endproperty
  a_in_update: assert property (p_in_update) else $error("input mode not updated");

  property p_readback;
    @(posedge CLK) disable iff (RESET)
    (wr_fire && opt_hit[0] && wbyte[pdpoc_pkg::PDPOC_RDSET_BIT] &&
     wbyte[pdpoc_pkg::PDPOC_KIND_BIT] == pdpoc_pkg::PDPOC_KIND_OUT) |=>
      rd_mode_all[0] == out_mode_all[$past(wbyte[2:0])];
  endproperty
  a_readback: assert property (p_readback) else $error("read selection not recorded");

  property p_read_data;
    @(posedge CLK) disable iff (RESET)
    (setup_cycle && !PWRITE && opt_hit[0]) |=> PRDATA == {24'h00_0000, rd_mode_all[0], 5'h00};
  endproperty
  a_read_data: assert property (p_read_data) else $error("option read data wrong");

  property p_access_one_cycle;
    @(posedge CLK) disable iff (RESET)
    (setup_cycle ##1 (PSEL && PENABLE)) |-> PREADY;
  endproperty
  a_access_one_cycle: assert property (p_access_one_cycle) else $error("access phase stalled");

  property p_unmapped_err;
    @(posedge CLK) disable iff (RESET)
    (setup_cycle && !any_hit) ##1 (PSEL && PENABLE) |-> PSLVERR;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access without error");

  property p_in_off_blocks;
    @(posedge CLK) disable iff (RESET)
    (in_mode_all[10] == pdpoc_pkg::PDPOC_IN_OFF) |=> !PORT_IN_DATA[10];
  endproperty
  a_in_off_blocks: assert property (p_in_off_blocks) else $error("disabled input passed data");

endmodule

// ===== common/pdpoc_pkg.sv
// Shared constants for the port direction and pin option configuration block
package pdpoc_pkg;

  localparam int PDPOC_MAX_PORTS = 4;
  localparam int PDPOC_PINS = 8;
  localparam int PDPOC_ADDR_W = 12;
  localparam int PDPOC_IDX_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] PDPOC_DIR_IDX [PDPOC_MAX_PORTS] = '{8'h93, 8'h94, 8'h95, 8'h96};
  localparam logic [7:0] PDPOC_OPT_IDX [PDPOC_MAX_PORTS] = '{8'h9E, 8'h9F, 8'hA0, 8'hA1};

  localparam logic [7:0] PDPOC_DIR_RESET = 8'hFF;
  localparam logic [7:0] PDPOC_OPT_RESET = 8'h00;

  // Option register write fields
  localparam int PDPOC_SEL_LSB = 0;
  localparam int PDPOC_SEL_W = 3;
  localparam int PDPOC_RDSET_BIT = 3;
  localparam int PDPOC_KIND_BIT = 4;
  localparam int PDPOC_MODE_LSB = 5;
  localparam int PDPOC_MODE_W = 3;
  localparam int PDPOC_IN_MODE_W = 2;

  localparam logic PDPOC_KIND_OUT = 1'b0;
  localparam logic PDPOC_KIND_IN = 1'b1;

  localparam logic [2:0] PDPOC_OUT_NORMAL = 3'h0;
  localparam logic [2:0] PDPOC_OUT_HIGH = 3'h3;
  localparam logic [1:0] PDPOC_IN_PLAIN = 2'h0;
  localparam logic [1:0] PDPOC_IN_PULLDOWN = 2'h1;
  localparam logic [1:0] PDPOC_IN_PULLUP = 2'h2;
  localparam logic [1:0] PDPOC_IN_OFF = 2'h3;

  localparam logic [31:0] PDPOC_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PDPOC_APB_IDLE = 2'b01,
    PDPOC_APB_ACCESS = 2'b10
  } pdpoc_apb_t;

endpackage

// ===== hw/pdpoc_dir_reg.sv
// Direction register of one port
`timescale 1ns/1ps
module pdpoc_dir_reg (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] dir
);

  // A one makes the pin an input, so reset leaves every pin undriven
  always_ff @(posedge clk) begin
    if (reset) begin
      dir <= pdpoc_pkg::PDPOC_DIR_RESET;
    end else if (wr_en) begin
      dir <= wdata;
    end
  end

endmodule

// ===== hw/pdpoc_option_port.sv
// Indirect per-pin option storage of one port
`timescale 1ns/1ps
module pdpoc_option_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [pdpoc_pkg::PDPOC_PINS-1:0][2:0] out_mode,
  output logic [pdpoc_pkg::PDPOC_PINS-1:0][1:0] in_mode,
  output logic [2:0] rd_mode
);

  logic [2:0] sel;
  logic rdset;
  logic kind;
  logic [2:0] mode;
  logic out_legal;
  logic [2:0] rd_sel;
  logic rd_kind;

  assign sel = wdata[pdpoc_pkg::PDPOC_SEL_LSB +: pdpoc_pkg::PDPOC_SEL_W];
  assign rdset = wdata[pdpoc_pkg::PDPOC_RDSET_BIT];
  assign kind = wdata[pdpoc_pkg::PDPOC_KIND_BIT];
  assign mode = wdata[pdpoc_pkg::PDPOC_MODE_LSB +: pdpoc_pkg::PDPOC_MODE_W];
  // Illegal output codes are dropped so a pin never sees an undefined drive
  assign out_legal = (mode == pdpoc_pkg::PDPOC_OUT_NORMAL) || (mode == pdpoc_pkg::PDPOC_OUT_HIGH);

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_sel <= 3'h0;
      rd_kind <= pdpoc_pkg::PDPOC_KIND_OUT;
    end else if (wr_en && rdset) begin
      rd_sel <= sel;
      rd_kind <= kind;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int n = 0; n < pdpoc_pkg::PDPOC_PINS; n++) begin
        out_mode[n] <= pdpoc_pkg::PDPOC_OPT_RESET[pdpoc_pkg::PDPOC_MODE_LSB +: pdpoc_pkg::PDPOC_MODE_W];
      end
    end else if (wr_en && !rdset && kind == pdpoc_pkg::PDPOC_KIND_OUT && out_legal) begin
      out_mode[sel] <= mode;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int n = 0; n < pdpoc_pkg::PDPOC_PINS; n++) begin
        in_mode[n] <= pdpoc_pkg::PDPOC_OPT_RESET[pdpoc_pkg::PDPOC_MODE_LSB +: pdpoc_pkg::PDPOC_IN_MODE_W];
      end
    end else if (wr_en && !rdset && kind == pdpoc_pkg::PDPOC_KIND_IN) begin
      in_mode[sel] <= mode[1:0];
    end
  end

  assign rd_mode = (rd_kind == pdpoc_pkg::PDPOC_KIND_IN) ? {1'b0, in_mode[rd_sel]} : out_mode[rd_sel];

  property p_illegal_out_dropped;
    @(posedge clk) disable iff (reset)
    (wr_en && !rdset && kind == pdpoc_pkg::PDPOC_KIND_OUT && !out_legal) |=> $stable(out_mode);
  endproperty
  a_illegal_out_dropped: assert property (p_illegal_out_dropped) else $error("illegal output mode stored");

endmodule

// ===== bench/pdpoc_tb_top.sv
// Self-checking APB testbench for the port direction and pin option block
`timescale 1ns/1ps
module pdpoc_tb_top;
  logic CLK;
  logic RESET;
  logic PSEL;
  logic PENABLE;
  logic PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [31:0] PIN_IN;
  logic [31:0] PORT_OUT_DATA;
  logic [31:0] PORT_IN_DATA;
  logic [31:0] PIN_OUT;
  logic [31:0] PIN_OE;
  logic [31:0] PIN_HIGH_DRIVE;
  logic [31:0] PIN_IN_EN;
  logic [31:0] PIN_PULL_UP;
  logic [31:0] PIN_PULL_DOWN;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] dirs;

  pdpoc_top #(.NUM_PORTS(4), .ADDR_W(12)) i_dut (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN),
    .PORT_OUT_DATA(PORT_OUT_DATA), .PORT_IN_DATA(PORT_IN_DATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_HIGH_DRIVE(PIN_HIGH_DRIVE), .PIN_IN_EN(PIN_IN_EN), .PIN_PULL_UP(PIN_PULL_UP),
    .PIN_PULL_DOWN(PIN_PULL_DOWN)
  );

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] dir_a(input int p);
    return {2'b00, pdpoc_pkg::PDPOC_DIR_IDX[p], 2'b00};
  endfunction

  function automatic logic [11:0] opt_a(input int p);
    return {2'b00, pdpoc_pkg::PDPOC_OPT_IDX[p], 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Holds the request until ready is seen at a rising edge, giving up with an error after 50 clocks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: no ready from slave", $time);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Pin outputs follow storage one clock after the write edge
  task automatic settle();
    repeat (2) @(posedge CLK);
    #1;
  endtask

  task automatic opt_wr(input int p, input logic [2:0] m, input logic k, input logic [2:0] pin);
    apb(1'b1, opt_a(p), {m, k, 1'b0, pin});
  endtask

  // Setup write selects pin and kind, then a read returns the mode in bits 7:5
  task automatic opt_chk(input int p, input logic k, input logic [2:0] pin, input logic [2:0] m, input string msg);
    apb(1'b1, opt_a(p), {3'h0, k, 1'b1, pin});
    apb(1'b0, opt_a(p), 8'h00);
    chk(rd, {24'h00_0000, m, 5'h00}, msg);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge CLK);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    PIN_IN = 32'hC3A5_5E3C;
    PORT_OUT_DATA = 32'h1234_5678;
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    settle();
    chk(PIN_OE, 32'h0000_0000, "reset pins not inputs");
    chk(PIN_IN_EN, 32'hFFFF_FFFF, "reset input buffers off");
    chk(PIN_PULL_UP | PIN_PULL_DOWN | PIN_HIGH_DRIVE, 32'h0000_0000, "reset pulls or drive");
    chk(PORT_IN_DATA, PIN_IN, "input path");
    chk(PIN_OUT, PORT_OUT_DATA, "output path");
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, dir_a(p), 8'h00);
      chk(rd, 32'h0000_00FF, "direction reset");
      opt_chk(p, 1'b0, 3'h0, 3'h0, "option reset");
    end
    $display("Test reset done");

    // Distinct pattern per port so a crossed address shows
    for (int p = 0; p < 4; p++) begin
      dirs[p*8+:8] = 8'hA5 ^ (8'h11 << p);
      apb(1'b1, dir_a(p), dirs[p*8+:8]);
    end
    settle();
    chk(PIN_OE, ~dirs, "pin drive from direction");
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, dir_a(p), 8'h00);
      chk(rd, {24'h00_0000, dirs[p*8+:8]}, "direction readback");
      chk({31'h0, err}, 32'h0000_0000, "error on mapped address");
    end
    $display("Test direction done");

    opt_wr(0, pdpoc_pkg::PDPOC_OUT_HIGH, pdpoc_pkg::PDPOC_KIND_OUT, 3'h5);
    opt_wr(3, pdpoc_pkg::PDPOC_OUT_HIGH, pdpoc_pkg::PDPOC_KIND_OUT, 3'h7);
    settle();
    chk(PIN_HIGH_DRIVE, 32'h8000_0020, "high drive pins");
    for (int m = 1; m < 8; m++) begin
      if (m != 3) begin
        opt_wr(0, 3'(m), pdpoc_pkg::PDPOC_KIND_OUT, 3'h5);
      end
    end
    // Setup write with a mode field that must not be stored
    apb(1'b1, opt_a(0), 8'h0D);
    opt_chk(0, 1'b0, 3'h5, 3'h3, "output mode readback");
    opt_wr(3, pdpoc_pkg::PDPOC_OUT_NORMAL, pdpoc_pkg::PDPOC_KIND_OUT, 3'h7);
    settle();
    chk(PIN_HIGH_DRIVE, 32'h0000_0020, "normal drive restored");
    opt_chk(3, 1'b0, 3'h7, 3'h0, "normal mode readback");
    $display("Test output options done");

    @(posedge CLK);
    PIN_IN <= 32'hFFFF_FFFF;
    for (int m = 0; m < 4; m++) begin
      opt_wr(1, {1'b0, 2'(m)}, pdpoc_pkg::PDPOC_KIND_IN, 3'h2);
      settle();
      chk(PIN_PULL_UP, {21'h0, (m == 2), 10'h0}, "pull up");
      chk(PIN_PULL_DOWN, {21'h0, (m == 1), 10'h0}, "pull down");
      chk(PIN_IN_EN, ~{21'h0, (m == 3), 10'h0}, "input buffer");
      chk(PORT_IN_DATA, ~{21'h0, (m == 3), 10'h0}, "input data when off");
      opt_chk(1, 1'b1, 3'h2, {1'b0, 2'(m)}, "input mode readback");
      opt_chk(1, 1'b0, 3'h2, 3'h0, "output kind untouched");
    end
    chk(PIN_HIGH_DRIVE, 32'h0000_0020, "other pins untouched");
    $display("Test input options done");

    apb(1'b1, 12'h25C, 8'h00);
    chk({31'h0, err}, 32'h0000_0001, "unmapped write error");
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 32'h0000_0000, "unmapped read data");
    chk({31'h0, err}, 32'h0000_0001, "unmapped read error");
    settle();
    chk(PIN_OE, ~dirs, "unmapped write ignored");
    $display("Test unmapped done");
    give_verdict();
  end
endmodule
